// ===== design/sanitize_seq.sv
// Sanitize pass sequencer with failed-block record and defect-data query.
// Assumes the media engine runs on pclk and answers each pass with media_done.
//
// Operation
// - Mask bit n selects partition n, bits 0 to 7.
// - First variant: fill with zeros, then full erase.
// - Second variant: full erase, then random fill.
// - Third variant: random fill, zero fill, then full erase to ones.
// - Fourth variant: random fill, then full erase.
// - Telemetry variant: erase, 0x55, erase, 0xAA, erase.
// - Record the first 16 failed erase or write blocks; host can read them.
// - Query is ten bytes, opcode 0x37, flags byte 2, length bytes 7-8.
// - Sub-code 0x0B keeps earlier bad-block records.
// - Reply bytes 2-3 hold failure count, bytes 4-7 block size.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sanitize_seq #(
   parameter logic [31:0] BLOCK_SIZE = 32'h0002_0000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic media_req,
   output logic [1:0] media_op,
   output logic [7:0] media_pattern,
   output logic [7:0] media_part,
   input wire logic media_done,
   input wire logic media_fail,
   input wire logic [31:0] media_fail_block,
   output logic sanitize_busy
);
   localparam int TBL_AW_W = sanitize_pkg::TBL_AW;
   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_state_t;
   typedef struct packed {
      seq_state_t st;
      sanitize_pkg::variant_t variant;
      logic [7:0] mask;
      logic [2:0] pass;
      logic req;
      logic [1:0] op;
      logic [7:0] pat;
      logic done;
      logic err;
      logic [15:0] fail_cnt;
      logic [31:0] cdb0;
      logic [31:0] cdb1;
      logic [31:0] cdb2;
      logic q_valid;
      logic q_err;
      logic plist;
      logic glist;
      logic [15:0] alloc;
      logic [TBL_AW_W-1:0] eidx;
      logic [31:0] rdata;
      logic rdy;
      logic slverr;
   } state_t;

   state_t s, next_s;
   logic [31:0] tbl [2**TBL_AW_W];
   logic access, wr, setup, tbl_we;
   sanitize_pkg::pass_t cur, nxt;
   logic [17:0] full_len;

   assign access = psel && penable && s.rdy;
   assign wr = access && pwrite;
   assign setup = psel && !penable;
   assign tbl_we = (s.st != S_IDLE) && media_fail && (s.fail_cnt < 16'(2**TBL_AW_W));

   always_comb begin
      next_s = s;
      cur = sanitize_pkg::pass_of(s.variant, s.pass);
      nxt = sanitize_pkg::pass_of(s.variant, s.pass + 3'h1);
      full_len = sanitize_pkg::REPLY_HDR + {s.fail_cnt, 2'b00};
      next_s.req = 1'b0;
      next_s.rdy = setup;
      // Sequencer
      unique case (s.st)
         S_IDLE: begin
            if (wr && paddr == sanitize_pkg::REG_CTRL && pwdata[0]) begin
               if (pwdata[3:1] > 3'(sanitize_pkg::V_TELEMETRY) ||
                   (pwdata[15:8] != sanitize_pkg::SUB_SANITIZE &&
                    pwdata[15:8] != sanitize_pkg::SUB_RETAIN)) begin
                  next_s.err = 1'b1;
               end else begin
                  next_s.variant = sanitize_pkg::variant_t'(pwdata[3:1]);
                  next_s.pass = 3'h0;
                  next_s.done = 1'b0;
                  next_s.err = 1'b0;
                  next_s.st = S_ISSUE;
                  // Plain sanitize starts a fresh record; the retain form keeps it
                  if (pwdata[15:8] == sanitize_pkg::SUB_SANITIZE) begin
                     next_s.fail_cnt = 16'h0000;
                  end
               end
            end
         end
         S_ISSUE: begin
            next_s.req = 1'b1;
            next_s.op = cur.op;
            next_s.pat = cur.pat;
            next_s.st = S_WAIT;
         end
         S_WAIT: begin
            if (media_done && !s.req) begin
               if (cur.last) begin
                  next_s.st = S_IDLE;
                  next_s.done = 1'b1;
               end else begin
                  next_s.pass = s.pass + 3'h1;
                  next_s.pat = nxt.pat;
                  next_s.st = S_ISSUE;
               end
            end
         end
      endcase
      // Failures while busy are counted up to CNT_MAX; the table keeps the first entries only
      if (s.st != S_IDLE && media_fail && s.fail_cnt != sanitize_pkg::CNT_MAX) begin
         next_s.fail_cnt = s.fail_cnt + 16'h0001;
      end
      // Register writes
      if (wr) begin
         unique case (paddr)
            sanitize_pkg::REG_MASK: begin
               if (s.st == S_IDLE) begin
                  next_s.mask = pwdata[7:0];
               end
            end
            sanitize_pkg::REG_CDB0: next_s.cdb0 = pwdata;
            sanitize_pkg::REG_CDB1: next_s.cdb1 = pwdata;
            sanitize_pkg::REG_CDB2: next_s.cdb2 = pwdata;
            sanitize_pkg::REG_EIDX: next_s.eidx = pwdata[TBL_AW_W-1:0];
            sanitize_pkg::REG_QCMD: begin
               // Only the opcode is checked; reserved fields pass unseen
               if (s.cdb0[31:24] == sanitize_pkg::OPC_DEFECT) begin
                  next_s.q_valid = 1'b1;
                  next_s.q_err = 1'b0;
                  next_s.plist = s.cdb0[12];
                  next_s.glist = s.cdb0[11];
                  next_s.alloc = {s.cdb1[7:0], s.cdb2[31:24]};
               end else begin
                  next_s.q_valid = 1'b0;
                  next_s.q_err = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Read data and error are prepared in the setup cycle
      if (setup) begin
         next_s.slverr = 1'b0;
         next_s.rdata = 32'h0000_0000;
         unique case (paddr)
            sanitize_pkg::REG_CTRL: next_s.rdata = {28'h0, 3'(s.variant), 1'b0};
            sanitize_pkg::REG_MASK: next_s.rdata = {24'h0, s.mask};
            sanitize_pkg::REG_STATUS:
               next_s.rdata = {s.fail_cnt, 5'h0, s.q_err, s.q_valid, s.pass,
                  s.err, s.done, 3'h0, (s.st != S_IDLE)};
            sanitize_pkg::REG_CDB0: next_s.rdata = s.cdb0;
            sanitize_pkg::REG_CDB1: next_s.rdata = s.cdb1;
            sanitize_pkg::REG_CDB2: next_s.rdata = s.cdb2;
            sanitize_pkg::REG_QCMD: next_s.rdata = 32'h0000_0000;
            sanitize_pkg::REG_REPLY0: begin
               if (s.q_valid) begin
                  next_s.rdata = {8'h00, 3'h0, s.plist, s.glist, sanitize_pkg::LIST_FMT,
                     s.fail_cnt};
               end
            end
            sanitize_pkg::REG_REPLY1: begin
               if (s.q_valid) begin
                  next_s.rdata = BLOCK_SIZE;
               end
            end
            sanitize_pkg::REG_EIDX: next_s.rdata = 32'(s.eidx);
            sanitize_pkg::REG_ENTRY: next_s.rdata = tbl[s.eidx];
            sanitize_pkg::REG_RLEN: begin
               if (s.q_valid) begin
                  next_s.rdata = (full_len > {2'b00, s.alloc}) ? {16'h0, s.alloc}
                     : {14'h0, full_len};
               end
            end
            default: next_s.slverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Table memory has no reset; the count says which entries are live
   always_ff @(posedge pclk) begin
      if (tbl_we) begin
         tbl[s.fail_cnt[TBL_AW_W-1:0]] <= media_fail_block;
      end
   end

   assign prdata = s.rdata;
   assign pready = s.rdy;
   assign pslverr = s.slverr;
   assign media_req = s.req;
   assign media_op = s.op;
   assign media_pattern = s.pat;
   assign media_part = s.mask;
   assign sanitize_busy = (s.st != S_IDLE) ? 1'b1 : 1'b0;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PART_HELD: assert property (media_req |-> media_part == $past(media_part, 2))
      else $error("Partition mask changed during a pass");
   AST_V1_ORDER: assert property (media_req && s.variant == sanitize_pkg::V_ZERO_ERASE
      |-> (s.pass == 3'h0) ? (media_op == 2'(sanitize_pkg::OP_FILL_CONST) &&
      media_pattern == 8'h00) : media_op == 2'(sanitize_pkg::OP_ERASE))
      else $error("Zero fill then erase order broken");
   AST_V2_ORDER: assert property (media_req && s.variant == sanitize_pkg::V_ERASE_RANDOM
      |-> media_op == ((s.pass == 3'h0) ? 2'(sanitize_pkg::OP_ERASE)
      : 2'(sanitize_pkg::OP_FILL_RANDOM)))
      else $error("Erase then random fill order broken");
   AST_V3_ERASE_LAST: assert property (media_req && s.variant == sanitize_pkg::V_RANDOM_ZERO_ERASE
      && s.pass == 3'h2 |-> media_op == 2'(sanitize_pkg::OP_ERASE) && s.st == S_WAIT)
      else $error("Third variant does not end with erase");
   AST_V4_END: assert property (s.variant == sanitize_pkg::V_RANDOM_ERASE && s.st == S_WAIT
      && s.pass == 3'h1 && media_done && !media_req |=> s.done && s.st == S_IDLE)
      else $error("Fourth variant not done after two passes");
   AST_TEL_PATTERN: assert property (media_req && s.variant == sanitize_pkg::V_TELEMETRY
      && s.pass[0] |-> media_pattern == ((s.pass == 3'h1) ? 8'h55 : 8'haa))
      else $error("Telemetry pattern wrong");
   AST_FAIL_COUNT: assert property (s.st != S_IDLE && media_fail && s.fail_cnt != 16'hffff
      |=> s.fail_cnt == $past(s.fail_cnt) + 16'h0001)
      else $error("Failed block not counted");
   AST_QUERY_OK: assert property (wr && paddr == sanitize_pkg::REG_QCMD
      && s.cdb0[31:24] == 8'h37 |=> s.q_valid && s.alloc == {$past(s.cdb1[7:0]),
      $past(s.cdb2[31:24])})
      else $error("Defect query not accepted");
   AST_RETAIN: assert property (wr && paddr == sanitize_pkg::REG_CTRL && pwdata[0]
      && pwdata[15:8] == 8'h0b && s.st == S_IDLE && pwdata[3:1] < 3'h5
      |=> s.fail_cnt == $past(s.fail_cnt) && s.st == S_ISSUE)
      else $error("Retain start lost records");
   AST_REPLY_COUNT: assert property (setup && paddr == sanitize_pkg::REG_REPLY0 && s.q_valid
      ##1 pready |-> prdata[15:0] == $past(s.fail_cnt) && prdata[2+16:16] == 3'h7)
      else $error("Reply count wrong");
   AST_APB_ONE_WAIT: assert property (setup |=> pready ##1 !pready)
      else $error("Access phase length wrong");
endmodule : sanitize_seq
`default_nettype wire

// ===== design/sanitize_pkg.sv
// Shared constants and types for the sanitize sequencer and failed-block query.
// Assumes a single pclk domain and an APB master issuing 32-bit word accesses.
package sanitize_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MASK = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_CDB0 = 8'h0c;
   localparam logic [7:0] REG_CDB1 = 8'h10;
   localparam logic [7:0] REG_CDB2 = 8'h14;
   localparam logic [7:0] REG_QCMD = 8'h18;
   localparam logic [7:0] REG_REPLY0 = 8'h1c;
   localparam logic [7:0] REG_REPLY1 = 8'h20;
   localparam logic [7:0] REG_EIDX = 8'h24;
   localparam logic [7:0] REG_ENTRY = 8'h28;
   localparam logic [7:0] REG_RLEN = 8'h2c;
   // Command codes, fill patterns and reply fields
   localparam logic [7:0] SUB_SANITIZE = 8'h0a;
   localparam logic [7:0] SUB_RETAIN = 8'h0b;
   localparam logic [7:0] OPC_DEFECT = 8'h37;
   localparam logic [7:0] PAT_ZERO = 8'h00;
   localparam logic [7:0] PAT_55 = 8'h55;
   localparam logic [7:0] PAT_AA = 8'haa;
   localparam logic [2:0] LIST_FMT = 3'h7;
   localparam logic [17:0] REPLY_HDR = 18'h00008;
   // Failed-block table
   localparam int TBL_AW = 4;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   typedef enum logic [1:0] {OP_ERASE, OP_FILL_CONST, OP_FILL_RANDOM} media_op_t;
   typedef enum logic [2:0] {V_ZERO_ERASE, V_ERASE_RANDOM, V_RANDOM_ZERO_ERASE,
      V_RANDOM_ERASE, V_TELEMETRY} variant_t;
   typedef struct packed {
      logic last;
      media_op_t op;
      logic [7:0] pat;
   } pass_t;
   // Pass table of each procedure variant
   function automatic pass_t pass_of(input variant_t v, input logic [2:0] i);
      pass_t p;
      p = '{last: 1'b1, op: OP_ERASE, pat: PAT_ZERO};
      unique case (v)
         V_ZERO_ERASE: begin
            p.op = (i == 3'h0) ? OP_FILL_CONST : OP_ERASE;
            p.last = (i == 3'h1);
         end
         V_ERASE_RANDOM: begin
            p.op = (i == 3'h0) ? OP_ERASE : OP_FILL_RANDOM;
            p.last = (i == 3'h1);
         end
         V_RANDOM_ZERO_ERASE: begin
            p.op = (i == 3'h0) ? OP_FILL_RANDOM : (i == 3'h1) ? OP_FILL_CONST : OP_ERASE;
            p.last = (i == 3'h2);
         end
         V_RANDOM_ERASE: begin
            p.op = (i == 3'h0) ? OP_FILL_RANDOM : OP_ERASE;
            p.last = (i == 3'h1);
         end
         V_TELEMETRY: begin
            p.op = i[0] ? OP_FILL_CONST : OP_ERASE;
            p.pat = (i == 3'h1) ? PAT_55 : PAT_AA;
            p.last = (i == 3'h4);
         end
         default: p = '{last: 1'b1, op: OP_ERASE, pat: PAT_ZERO};
      endcase
      return p;
   endfunction : pass_of
endpackage : sanitize_pkg

// ===== tb/media_model.sv
// Behavioural media engine that answers each pass after a random delay.
// Assumes media_req is a one-cycle pulse on pclk and one pass is outstanding.
`timescale 1ns/10ps
`default_nettype none
module media_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic media_req,
   input wire logic fail_en,
   output logic media_done,
   output logic media_fail,
   output logic [31:0] media_fail_block
);
   int cnt;
   logic [31:0] nxt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         nxt <= 32'h0000_0100;
         media_done <= 1'b0;
         media_fail <= 1'b0;
         media_fail_block <= 32'h5a5a_5a5a;
      end else begin
         media_done <= 1'b0;
         media_fail <= 1'b0;
         // Block number is only meaningful with media_fail, so keep it moving
         media_fail_block <= ~media_fail_block;
         if (media_req) begin
            cnt <= 3 + ($urandom % 6);
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 2 && fail_en) begin
               media_fail <= 1'b1;
               media_fail_block <= nxt;
               nxt <= nxt + 32'h3;
            end
            if (cnt == 1) begin
               media_done <= 1'b1;
            end
         end
      end
   end
endmodule : media_model
`default_nettype wire

// ===== tb/sanitize_sequencer_and_defect_query_test.sv
// Self-checking bench: pass orders, partition mask, failure record and query.
// Assumes the sequencer register map and the media model beside it.
`timescale 1ns/10ps
`default_nettype none
module sanitize_sequencer_and_defect_query_test;
   localparam logic [31:0] BSZ = 32'h0000_4000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic media_req, media_done, media_fail, sanitize_busy, fail_en;
   logic [7:0] paddr, media_pattern, media_part, m, b2;
   logic [1:0] media_op;
   logic [15:0] al, c;
   logic [31:0] pwdata, prdata, media_fail_block, r;
   logic [17:0] seen[$];
   logic [31:0] fails[$];
   int n_fail, compares, np[5];
   sanitize_seq #(.BLOCK_SIZE(BSZ)) u_sanitize_seq (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .media_req(media_req),
      .media_op(media_op), .media_pattern(media_pattern), .media_part(media_part),
      .media_done(media_done), .media_fail(media_fail),
      .media_fail_block(media_fail_block), .sanitize_busy(sanitize_busy));
   media_model u_media_model (.pclk(pclk), .presetn(presetn), .media_req(media_req),
      .fail_en(fail_en), .media_done(media_done), .media_fail(media_fail),
      .media_fail_block(media_fail_block));
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (media_req) seen.push_back({media_op, media_pattern, media_part});
      if (media_fail && sanitize_busy) fails.push_back(media_fail_block);
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic give_verdict();
      if (n_fail == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 32'h0, 32'h1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic run(input logic [2:0] v, input logic [7:0] sub);
      int n;
      seen.delete();
      apb(1'b1, sanitize_pkg::REG_CTRL, {16'h0, sub, 4'h0, v, 1'b1}, r);
      n = 0;
      do begin
         apb(1'b0, sanitize_pkg::REG_STATUS, 32'h0, r);
         n++;
      end while ((r[0] !== 1'b0 || r[4] !== 1'b1) && n < 300);
      chk("done", {31'h0, r[4]}, 32'h1);
   endtask : run
   function automatic logic [1:0] exp_op(int v, int i);
      case (v)
         0: return i == 0 ? 2'd1 : 2'd0;
         1: return i == 0 ? 2'd0 : 2'd2;
         2: return i == 0 ? 2'd2 : (i == 1 ? 2'd1 : 2'd0);
         3: return i == 0 ? 2'd2 : 2'd0;
         default: return (i % 2) ? 2'd1 : 2'd0;
      endcase
   endfunction : exp_op
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, fail_en} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      np = '{2, 2, 3, 2, 5};
      void'($urandom(32'hd13e94a0));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, sanitize_pkg::REG_STATUS, 32'h0, r);
      chk("status_rst", r, 32'h0);
      apb(1'b0, 8'h30, 32'h0, r);
      chk("unmapped", {31'h0, slv}, 32'h1);
      for (int v = 0; v < 5; v++) begin
         m = (v == 0) ? 8'h01 : (v == 1) ? 8'h80 : 8'($urandom);
         apb(1'b1, sanitize_pkg::REG_MASK, {24'h0, m}, r);
         apb(1'b0, sanitize_pkg::REG_MASK, 32'h0, r);
         chk("mask", r, {24'h0, m});
         run(3'(v), sanitize_pkg::SUB_SANITIZE);
         chk("passes", 32'(seen.size()), 32'(np[v]));
         foreach (seen[i]) begin
            chk("op", {30'h0, seen[i][17:16]}, {30'h0, exp_op(v, i)});
            b2 = (v == 4) ? ((i == 1) ? 8'h55 : 8'haa) : 8'h00;
            if (seen[i][17:16] == 2'd1) chk("pat", {24'h0, seen[i][15:8]}, {24'h0, b2});
            chk("part", {24'h0, seen[i][7:0]}, {24'h0, m});
         end
      end
      apb(1'b1, sanitize_pkg::REG_CTRL, {16'h0, sanitize_pkg::SUB_SANITIZE, 8'h0b}, r);
      apb(1'b0, sanitize_pkg::REG_STATUS, 32'h0, r);
      chk("bad_variant", {30'h0, r[5], r[0]}, 32'h2);
      fails.delete();
      fail_en <= 1'b1;
      run(3'd4, sanitize_pkg::SUB_SANITIZE);
      foreach (fails[i]) begin
         apb(1'b1, sanitize_pkg::REG_EIDX, 32'(i), r);
         apb(1'b0, sanitize_pkg::REG_ENTRY, 32'h0, r);
         chk("entry", r, fails[i]);
      end
      run(3'd1, sanitize_pkg::SUB_RETAIN);
      fail_en <= 1'b0;
      apb(1'b0, sanitize_pkg::REG_STATUS, 32'h0, r);
      chk("count", {16'h0, r[31:16]}, 32'(fails.size()));
      c = r[31:16];
      for (int q = 0; q < 4; q++) begin
         b2 = 8'($urandom);
         al = (q == 0) ? 16'h0001 : 16'($urandom % 64);
         apb(1'b1, sanitize_pkg::REG_CDB0, {(q == 3) ? 8'h36 : 8'h37, 8'($urandom), b2,
            8'($urandom)}, r);
         apb(1'b1, sanitize_pkg::REG_CDB1, {24'($urandom), al[15:8]}, r);
         apb(1'b1, sanitize_pkg::REG_CDB2, {al[7:0], 8'($urandom), 16'h0}, r);
         apb(1'b1, sanitize_pkg::REG_QCMD, $urandom, r);
         apb(1'b0, sanitize_pkg::REG_REPLY0, 32'h0, r);
         chk("reply0", r, (q == 3) ? 32'h0 : {11'h0, b2[4:3], 3'h7, c});
         apb(1'b0, sanitize_pkg::REG_STATUS, 32'h0, r);
         chk("qflags", {30'h0, r[10:9]}, (q == 3) ? 32'h2 : 32'h1);
         if (q == 3) continue;
         apb(1'b0, sanitize_pkg::REG_REPLY1, 32'h0, r);
         chk("reply1", r, BSZ);
         apb(1'b0, sanitize_pkg::REG_RLEN, 32'h0, r);
         chk("rlen", r, (32'(al) < 32'h8 + 32'(c) * 4) ? 32'(al) : 32'h8 + 32'(c) * 4);
      end
      give_verdict();
   end
   initial begin
      #(60000 * 5);
      n_fail++;
      give_verdict();
   end
endmodule : sanitize_sequencer_and_defect_query_test
`default_nettype wire
